// >>> verilog/cre_engine.sv
/*
  capture record engine: receive framing into a host ring, transmit pass.
  assumes host memory accepts one word write per cycle and the line
  takes one transmit word per cycle; network beats share this clock.
*/
// Decided for this implementation: the plain strobed port and the address map.
// How it works
// - snap length resets to 48 bytes of payload per record
// - variable mode stores short packets whole, record shrinks to fit
// - packets longer than snap length are cut to snap length bytes
// - fixed mode pads short packets up to the snap length
// - every record is a 16-byte header then payload; length is 16 plus payload
// - each port capture enable; disabled ports produce no records
// - each accepted packet writes one record into the receive ring
// - full receive ring discards new packets until host frees space
// - discards are counted and reported in the next record header
// - activity lamp blinks while the receive ring is full
// - buffer megabytes split between receive stream 0 and transmit stream 1
// - default split gives receive all memory, transmit none
// - combined option gives transmit 16 MiB, receive keeps the rest
// - engine never originates frames; only host records go out
// - host record payloads are sent at full line rate, with four idle cycles where each header is dropped
// - capture continues while transmit is running
// - alignment option rounds every record length to 64 bits
`timescale 1ns/1ps
`default_nettype none
module cre_engine #(
  parameter int NUM_PORTS = 4,
  parameter int TOTAL_MB = 32,
  parameter logic [31:0] RX_BASE = 32'h0000_0000,
  parameter logic [7:0] REC_TYPE = 8'h01, // arbitrary value
  parameter int LED_TICK_CYCLES = cre_pkg::LED_TICK_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  input wire cre_pkg::cre_rx_beat_s i_rx,
  output logic o_rx_ready,
  output cre_pkg::cre_mem_wr_s o_mem,
  input wire cre_pkg::cre_tx_word_s i_tx,
  output logic o_tx_ready,
  output cre_pkg::cre_tx_word_s o_line,
  output logic o_capture_led
);
  initial begin
    if (NUM_PORTS < 1 || NUM_PORTS > 4) $error("NUM_PORTS must be 1..4");
    if (TOTAL_MB <= 16 || TOTAL_MB > 4095) $error("TOTAL_MB out of range");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_PAYLOAD, ST_DROP, ST_PAD, ST_HDR} cre_state_e;

  function automatic logic [31:0] ring_add(input logic [31:0] off, input logic [31:0] inc,
                                           input logic [31:0] size);
    logic [31:0] sum;
    sum = off + inc;
    ring_add = (sum >= size) ? sum - size : sum;
  endfunction

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  logic varlen_q;
  logic align_q;
  logic [NUM_PORTS-1:0] port_en_q;
  logic [11:0] snap_q;
  logic [15:0] tx_mb_q;
  logic [31:0] rd_ptr_q;
  logic [31:0] wr_ptr_q;
  logic [31:0] loss_total_q;
  logic [31:0] rdata_q;

  cre_state_e state_q, state_d;
  logic tx_busy_q;

  wire logic busy = (state_q != ST_IDLE) || tx_busy_q;
  wire logic wr_ctrl = i_reg_wr && i_reg_addr == cre_pkg::REG_CTRL;
  wire logic wr_snap = i_reg_wr && i_reg_addr == cre_pkg::REG_SNAP;
  wire logic wr_mem = i_reg_wr && i_reg_addr == cre_pkg::REG_MEM;
  wire logic wr_rdp = i_reg_wr && i_reg_addr == cre_pkg::REG_RD_PTR;
  wire logic [15:0] rx_mb = 16'(TOTAL_MB) - tx_mb_q;
  wire logic [31:0] ring_size = {rx_mb[11:0], 20'h0_0000};

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      varlen_q <= cre_pkg::VARLEN_RST;
      align_q <= cre_pkg::ALIGN_RST;
      port_en_q <= '1;
      snap_q <= cre_pkg::SNAP_RST;
      tx_mb_q <= cre_pkg::TX_MB_RST;
      rd_ptr_q <= 32'h0000_0000;
    end else begin
      if (wr_ctrl) begin
        varlen_q <= i_reg_wdata[cre_pkg::CTRL_VARLEN];
        align_q <= i_reg_wdata[cre_pkg::CTRL_ALIGN];
        port_en_q <= i_reg_wdata[cre_pkg::CTRL_EN_LSB +: NUM_PORTS];
      end
      // split stays put while traffic runs
      if (wr_ctrl && i_reg_wdata[cre_pkg::CTRL_RXTX] && !busy) begin
        tx_mb_q <= cre_pkg::RXTX_TX_MB;
      end else if (wr_mem && !busy && i_reg_wdata[15:0] < 16'(TOTAL_MB)) begin
        tx_mb_q <= i_reg_wdata[15:0];
      end
      if (wr_snap) begin
        snap_q <= {i_reg_wdata[11:2], 2'b00};
      end
      if (wr_rdp) begin
        rd_ptr_q <= i_reg_wdata;
      end
    end
  end

  // --------------------------------------------------------------------------
  // ring occupancy
  // --------------------------------------------------------------------------
  wire logic [31:0] used = (wr_ptr_q >= rd_ptr_q) ? wr_ptr_q - rd_ptr_q
                                                  : ring_size - rd_ptr_q + wr_ptr_q;
  wire logic [31:0] need = {20'h0_0000, snap_q} + 32'h0000_0018;
  // one worst-case record must fit, so a record never overruns the reader
  wire logic full = (ring_size - used) <= need;

  // --------------------------------------------------------------------------
  // receive path
  // --------------------------------------------------------------------------
  logic [31:0] base_q;
  logic [15:0] bytes_q;
  logic [9:0] word_q;
  logic [1:0] hdr_idx_q;
  logic [1:0] port_q;
  logic [15:0] lctr_q;
  logic [63:0] ts_q;
  logic [63:0] ts_cap_q;
  logic rx_ready_q;
  cre_pkg::cre_mem_wr_s mem_q;
  logic [11:0] body;
  logic [15:0] rec_len;

  cre_len_calc u_len (
    .i_snap(snap_q),
    .i_wire_len(bytes_q),
    .i_varlen(varlen_q),
    .i_align(align_q),
    .o_body(body),
    .o_rec_len(rec_len)
  );

  wire logic accept = i_rx.valid && rx_ready_q;
  wire logic start = accept && i_rx.sop && state_q == ST_IDLE;
  wire logic port_ok = |(4'(port_en_q) & (4'h1 << i_rx.port));
  wire logic take = start && port_ok && !full;
  wire logic drop_evt = start && port_ok && full;
  wire logic beat_in = take || (accept && state_q == ST_PAYLOAD);
  wire logic [9:0] snap_words = {snap_q[11:2]};
  wire logic [9:0] body_words = {body[11:2]} + {9'h000, body[1] | body[0]};
  wire logic [9:0] word_now = take ? 10'h000 : word_q;
  wire logic beat_wr = beat_in && word_now < snap_words;
  wire logic pad_wr = state_q == ST_PAD && word_q < body_words;
  wire logic hdr_wr = state_q == ST_HDR;
  wire logic [31:0] cur_base = take ? wr_ptr_q : base_q;
  wire logic [31:0] pay_off = 32'({word_now, 2'b00}) + 32'(cre_pkg::HDR_BYTES);
  wire logic [31:0] pay_addr = ring_add(cur_base, pay_off, ring_size);
  wire logic [31:0] hdr_addr = ring_add(base_q, 32'({hdr_idx_q, 2'b00}), ring_size);
  wire logic [2:0] nb = i_rx.eop ? i_rx.nbytes : 3'h4;
  wire logic [31:0] byte_mask = (nb >= 3'h4) ? 32'hFFFF_FFFF
                              : (32'h0000_0001 << {nb, 3'b000}) - 32'h0000_0001;
  wire logic [31:0] beat_data = i_rx.data & byte_mask;
  wire logic [15:0] lctr_next = (lctr_q == 16'hFFFF) ? lctr_q : lctr_q + 16'h0001;
  wire logic lctr_take = hdr_wr && hdr_idx_q == 2'd3;
  wire logic [31:0] step = 32'((rec_len + 16'h0003) & 16'hFFFC);

  logic [31:0] hdr_word;
  always_comb begin
    unique case (hdr_idx_q)
      2'd0: hdr_word = ts_cap_q[31:0];
      2'd1: hdr_word = ts_cap_q[63:32];
      2'd2: hdr_word = {rec_len, 6'b00_0000, port_q, REC_TYPE};
      2'd3: hdr_word = {bytes_q, lctr_q};
    endcase
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (start && !take && !i_rx.eop) begin
          state_d = ST_DROP;
        end else if (take) begin
          state_d = i_rx.eop ? ST_PAD : ST_PAYLOAD;
        end
      end
      ST_PAYLOAD: begin
        if (accept && i_rx.eop) begin
          state_d = ST_PAD;
        end
      end
      ST_DROP: begin
        if (accept && i_rx.eop) begin
          state_d = ST_IDLE;
        end
      end
      ST_PAD: begin
        if (!pad_wr) begin
          state_d = ST_HDR;
        end
      end
      ST_HDR: begin
        if (hdr_idx_q == 2'd3) begin
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= ST_IDLE;
      rx_ready_q <= 1'b0;
      ts_q <= 64'h0000_0000_0000_0000;
    end else begin
      state_q <= state_d;
      // stall the source while padding and header words occupy the port
      rx_ready_q <= state_d == ST_IDLE || state_d == ST_PAYLOAD || state_d == ST_DROP;
      ts_q <= ts_q + 64'h0000_0000_0000_0001;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      base_q <= 32'h0000_0000;
      bytes_q <= 16'h0000;
      word_q <= 10'h000;
      hdr_idx_q <= 2'd0;
      port_q <= 2'd0;
      ts_cap_q <= 64'h0000_0000_0000_0000;
      wr_ptr_q <= 32'h0000_0000;
    end else begin
      if (take) begin
        base_q <= wr_ptr_q;
        port_q <= i_rx.port;
        ts_cap_q <= ts_q;
        bytes_q <= {13'h0000, nb};
      end else if (beat_in) begin
        bytes_q <= bytes_q + {13'h0000, nb};
      end
      if (beat_wr || pad_wr) begin
        word_q <= word_now + 10'h001;
      end else if (take) begin
        word_q <= 10'h000;
      end
      hdr_idx_q <= hdr_wr ? hdr_idx_q + 2'd1 : 2'd0;
      if (lctr_take) begin
        wr_ptr_q <= ring_add(base_q, step, ring_size);
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      lctr_q <= 16'h0000;
      loss_total_q <= 32'h0000_0000;
    end else begin
      // a drop in the clearing cycle still counts
      if (drop_evt) begin
        lctr_q <= lctr_take ? 16'h0001 : lctr_next;
        loss_total_q <= loss_total_q + 32'h0000_0001;
      end else if (lctr_take) begin
        lctr_q <= 16'h0000;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      mem_q <= '0;
    end else begin
      mem_q.valid <= beat_wr || pad_wr || hdr_wr;
      mem_q.addr <= RX_BASE + (hdr_wr ? hdr_addr : pay_addr);
      mem_q.data <= hdr_wr ? hdr_word : (pad_wr ? 32'h0000_0000 : beat_data);
    end
  end

  // --------------------------------------------------------------------------
  // transmit path
  // --------------------------------------------------------------------------
  logic [2:0] tx_skip_q;
  logic tx_ready_q;
  cre_pkg::cre_tx_word_s line_q;
  wire logic tx_en = tx_mb_q != 16'h0000;
  wire logic tx_take = i_tx.valid && tx_ready_q;
  wire logic tx_body = tx_take && tx_skip_q == 3'd4;

  // independent of the receive machine, so capture never pauses
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      tx_skip_q <= 3'd0;
      tx_ready_q <= 1'b0;
      tx_busy_q <= 1'b0;
      line_q <= '0;
    end else begin
      tx_ready_q <= tx_en;
      if (tx_take) begin
        tx_skip_q <= i_tx.last ? 3'd0 : (tx_skip_q == 3'd4 ? tx_skip_q : tx_skip_q + 3'd1);
        tx_busy_q <= !i_tx.last;
      end
      // header words stay home; only host payload reaches the line
      line_q.valid <= tx_body;
      line_q.last <= tx_body && i_tx.last;
      line_q.data <= tx_body ? i_tx.data : 32'h0000_0000;
    end
  end

  // --------------------------------------------------------------------------
  // register read and lamp
  // --------------------------------------------------------------------------
  wire logic [31:0] ctrl_rd = 32'({port_en_q, 6'h00, align_q, varlen_q});
  wire logic [31:0] stat_rd = {29'h0000_0000, tx_busy_q, state_q != ST_IDLE, full};

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rdata_q <= 32'h0000_0000;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        cre_pkg::REG_CTRL: rdata_q <= ctrl_rd;
        cre_pkg::REG_SNAP: rdata_q <= {20'h0_0000, snap_q};
        cre_pkg::REG_MEM: rdata_q <= {rx_mb, tx_mb_q};
        cre_pkg::REG_TOTAL: rdata_q <= 32'(TOTAL_MB);
        cre_pkg::REG_RD_PTR: rdata_q <= rd_ptr_q;
        cre_pkg::REG_WR_PTR: rdata_q <= wr_ptr_q;
        cre_pkg::REG_LOSS: rdata_q <= loss_total_q;
        cre_pkg::REG_STATUS: rdata_q <= stat_rd;
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  cre_led #(
    .TICK_CYCLES(LED_TICK_CYCLES)
  ) u_led (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_activity(lctr_take),
    .i_full(full),
    .o_led(o_capture_led)
  );

  assign o_reg_rdata = rdata_q;
  assign o_rx_ready = rx_ready_q;
  assign o_mem = mem_q;
  assign o_tx_ready = tx_ready_q;
  assign o_line = line_q;
endmodule
`default_nettype wire

// >>> verilog/cre_pkg.sv
/*
  constants, register map and carrier types of the capture record engine.
  assumes a 100 MHz core clock and a 32-bit little-endian data path.
*/
`default_nettype none
package cre_pkg;
  // --------------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int LED_TICK_MS = 50;
  localparam int LED_TICK_CYCLES = LED_TICK_MS * 1000000 / CLK_PERIOD_NS;

  // --------------------------------------------------------------------------
  // register map
  // --------------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SNAP = 8'h04;
  localparam logic [7:0] REG_MEM = 8'h08;
  localparam logic [7:0] REG_TOTAL = 8'h0C;
  localparam logic [7:0] REG_RD_PTR = 8'h10;
  localparam logic [7:0] REG_WR_PTR = 8'h14;
  localparam logic [7:0] REG_LOSS = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1C;

  localparam int CTRL_VARLEN = 0;
  localparam int CTRL_ALIGN = 1;
  localparam int CTRL_RXTX = 2;
  localparam int CTRL_EN_LSB = 8;
  localparam int STAT_FULL = 0;
  localparam int STAT_RX_BUSY = 1;
  localparam int STAT_TX_BUSY = 2;

  localparam logic [11:0] SNAP_RST = 12'h030;
  localparam logic [11:0] SNAP_MIN = 12'h010;
  localparam logic [11:0] SNAP_MAX = 12'h7F8;
  localparam logic [15:0] HDR_BYTES = 16'h0010;
  localparam logic [15:0] RXTX_TX_MB = 16'h0010;
  localparam logic [15:0] TX_MB_RST = 16'h0000;
  localparam logic VARLEN_RST = 1'b1;
  localparam logic ALIGN_RST = 1'b0;

  // --------------------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic sop;
    logic eop;
    logic [1:0] port;
    logic [2:0] nbytes;
    logic [31:0] data;
  } cre_rx_beat_s;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [31:0] data;
  } cre_mem_wr_s;

  typedef struct packed {
    logic valid;
    logic last;
    logic [31:0] data;
  } cre_tx_word_s;
endpackage
`default_nettype wire

// >>> verilog/cre_len_calc.sv
/*
  stored payload length and record length of one capture record.
  assumes snap length already legal (multiple of 4, 16..2040).
*/
`timescale 1ns/1ps
`default_nettype none
module cre_len_calc (
  input wire logic [11:0] i_snap,
  input wire logic [15:0] i_wire_len,
  input wire logic i_varlen,
  input wire logic i_align,
  output logic [11:0] o_body,
  output logic [15:0] o_rec_len
);
  // --------------------------------------------------------------------------
  // length arithmetic
  // --------------------------------------------------------------------------
  wire logic longer = i_wire_len > {4'h0, i_snap};
  wire logic [11:0] cap = longer ? i_snap : i_wire_len[11:0];
  wire logic [11:0] raw = i_varlen ? cap : i_snap;
  wire logic [11:0] rnd = (raw + 12'h007) & 12'hFF8;

  assign o_body = i_align ? rnd : raw;
  assign o_rec_len = cre_pkg::HDR_BYTES + {4'h0, o_body};
endmodule
`default_nettype wire

// >>> verilog/cre_led.sv
/*
  capture activity indicator with its own slow tick divider.
  assumes activity is a one-cycle pulse per written record.
*/
`timescale 1ns/1ps
`default_nettype none
module cre_led #(
  parameter int TICK_CYCLES = cre_pkg::LED_TICK_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_activity,
  input wire logic i_full,
  output logic o_led
);
  initial begin
    if (TICK_CYCLES < 2) $error("tick too short");
  end

  // --------------------------------------------------------------------------
  // divider and stretch
  // --------------------------------------------------------------------------
  logic [31:0] div_q;
  logic seen_q;
  logic led_q;
  wire logic tick = div_q == 32'(TICK_CYCLES - 1);

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      div_q <= 32'h0000_0000;
      seen_q <= 1'b0;
      led_q <= 1'b0;
    end else begin
      div_q <= tick ? 32'h0000_0000 : div_q + 32'h0000_0001;
      if (tick) begin
        seen_q <= i_activity;
      end else if (i_activity) begin
        seen_q <= 1'b1;
      end
      // full buffer blinks instead of steady activity
      if (tick) begin
        led_q <= i_full ? ~led_q : seen_q;
      end
    end
  end

  assign o_led = led_q;
endmodule
`default_nettype wire

// >>> tb/cre_engine_checker.sv
/*
  port assertions of the capture record engine.
  assumes one clock and an active-high asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module cre_engine_checker (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_reg_wr,
  input wire cre_pkg::cre_tx_word_s i_tx,
  input wire logic o_tx_ready,
  input wire logic o_rx_ready,
  input wire cre_pkg::cre_mem_wr_s o_mem,
  input wire cre_pkg::cre_tx_word_s o_line
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // --------------------------------------------------------------------------
  // transmit
  // --------------------------------------------------------------------------
  chk_line_from_host: assert property (
    o_line.valid |-> $past(i_tx.valid && o_tx_ready)) else $error("line word without host word");
  chk_line_data_copy: assert property (
    o_line.valid |-> o_line.data == $past(i_tx.data) && o_line.last == $past(i_tx.last))
    else $error("line word differs from host word");
  chk_line_no_gap: assert property (
    o_line.valid && !o_line.last && i_tx.valid && o_tx_ready |=> o_line.valid)
    else $error("gap inside a sent record");
  chk_tx_off_default: assert property (
    $rose(o_tx_ready) |-> $past(i_reg_wr) || $past(i_reg_wr, 2) || $past(i_reg_wr, 3))
    else $error("transmit opened without a write");
  // --------------------------------------------------------------------------
  // receive
  // --------------------------------------------------------------------------
  chk_mem_word_addr: assert property (
    o_mem.valid |-> o_mem.addr[1:0] == 2'b00) else $error("unaligned memory write");
  chk_hdr_stall: assert property (
    $fell(o_rx_ready) |-> !o_rx_ready [*5]) else $error("header cycles cut short");
  chk_rx_resumes: assert property (
    $fell(o_rx_ready) |-> ##[5:600] o_rx_ready) else $error("receive never resumes");
  chk_record_write: assert property (
    $fell(o_rx_ready) |-> ##[0:8] o_mem.valid) else $error("no record write");
  cov_line_last: cover property (o_line.valid && o_line.last);
  cov_rx_stall: cover property ($fell(o_rx_ready));
  cov_tx_open: cover property ($rose(o_tx_ready));
endmodule
bind cre_engine cre_engine_checker chk_u (
  .i_clk(i_clk),
  .i_reset(i_reset),
  .i_reg_wr(i_reg_wr),
  .i_tx(i_tx),
  .o_tx_ready(o_tx_ready),
  .o_rx_ready(o_rx_ready),
  .o_mem(o_mem),
  .o_line(o_line)
);
`default_nettype wire

// >>> tb/cre_host_model.sv
/*
  host side: main memory taking record writes, plus a transmit record source.
  assumes the engine's clock; memory never stalls the engine.
*/
`timescale 1ns/1ps
`default_nettype none
module cre_host_model (
  input wire logic i_clk,
  input wire cre_pkg::cre_mem_wr_s i_mem,
  input wire logic i_tx_ready,
  output var cre_pkg::cre_tx_word_s o_tx
);
  logic [31:0] mem [logic [31:0]];
  initial o_tx = '{1'b0, 1'b0, 32'h5A5A_5A5A};
  always @(posedge i_clk) begin
    if (i_mem.valid) begin
      mem[i_mem.addr] = i_mem.data;
    end
  end
  // word 2 holds length and type; even word count keeps 64-bit records
  task automatic send_rec(input int words, input logic [7:0] rtype);
    for (int k = 0; k < words; k++) begin
      o_tx <= '{1'b1, k == words - 1,
                k == 2 ? {16'(words * 4), 8'h00, rtype} : 32'hBEEF_0000 + 32'(k)};
      do @(posedge i_clk); while (!i_tx_ready);
    end
    // released bus shows no stale word
    o_tx <= '{1'b0, 1'b0, ~o_tx.data};
  endtask
endmodule
`default_nettype wire

// >>> tb/test_cre_engine.sv
/*
  self-checking bench of the capture record engine.
  assumes the host model and checker files are compiled with it.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end
module test_cre_engine;
  localparam int LIMIT = 20000;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [7:0] i_reg_addr = 8'h00;
  logic [31:0] i_reg_wdata = 32'h0000_0000;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [31:0] o_reg_rdata;
  cre_pkg::cre_rx_beat_s i_rx = '0;
  logic o_rx_ready;
  cre_pkg::cre_mem_wr_s o_mem;
  cre_pkg::cre_tx_word_s i_tx;
  logic o_tx_ready;
  cre_pkg::cre_tx_word_s o_line;
  logic o_capture_led;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] wp = 32'h0000_0000;
  logic [31:0] base;
  logic [31:0] rd;
  logic [31:0] line_q [$];
  always #5 i_clk = ~i_clk;
  // short lamp tick keeps the full-ring blink visible in a short run
  cre_engine #(.REC_TYPE(8'h5A), .LED_TICK_CYCLES(8)) dut_u (
    .i_clk(i_clk), .i_reset(i_reset), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_rx(i_rx),
    .o_rx_ready(o_rx_ready), .o_mem(o_mem), .i_tx(i_tx), .o_tx_ready(o_tx_ready),
    .o_line(o_line), .o_capture_led(o_capture_led));
  cre_host_model host_u (.i_clk(i_clk), .i_mem(o_mem), .i_tx_ready(o_tx_ready), .o_tx(i_tx));
  always @(posedge i_clk) begin
    if (o_line.valid) begin
      line_q.push_back(o_line.data);
    end
  end
  // --------------------------------------------------------------------------
  // bus and packet tasks
  // --------------------------------------------------------------------------
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    @(posedge i_clk);
    rd = o_reg_rdata;
  endtask
  task automatic send_pkt(input logic [1:0] p, input int len);
    int n;
    n = (len + 3) / 4;
    for (int k = 0; k < n; k++) begin
      i_rx <= '{1'b1, k == 0, k == n - 1, p, 3'(len - 4 * k > 4 ? 4 : len - 4 * k),
                32'hC0DE_0000 + 32'(k)};
      do @(posedge i_clk); while (!o_rx_ready);
    end
    i_rx <= '{1'b0, 1'b0, 1'b0, 2'b00, 3'b000, ~i_rx.data};
    @(posedge i_clk);
    for (int i = 0; i < 600 && !o_rx_ready; i++) @(posedge i_clk);
    repeat (2) @(posedge i_clk);
  endtask
  task automatic rec(input logic [1:0] p, input int len, input int rlen, input logic [15:0] lc);
    send_pkt(p, len);
    base = wp;
    `CHK(host_u.mem[base + 32'd8], {16'(rlen), 6'b00_0000, p, 8'h5A})
    `CHK(host_u.mem[base + 32'd12], {16'(len), lc})
    `CHK(host_u.mem[base + 32'd16], 32'hC0DE_0000)
    wp = wp + 32'(rlen);
    reg_rd(cre_pkg::REG_WR_PTR);
    `CHK(rd, wp)
  endtask
  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  task automatic t_defaults;
    reg_rd(cre_pkg::REG_SNAP);
    `CHK(rd, 32'h0000_0030)
    reg_rd(cre_pkg::REG_MEM);
    `CHK(rd, 32'h0020_0000)
    reg_rd(cre_pkg::REG_TOTAL);
    `CHK(rd, 32'h0000_0020)
    reg_rd(8'h40);
    `CHK(rd, 32'h0000_0000)
    `CHK(o_tx_ready, 1'b0)
  endtask
  task automatic t_lengths;
    rec(2'd1, 8, 24, 16'h0000);
    rec(2'd2, 100, 64, 16'h0000);
    reg_wr(cre_pkg::REG_SNAP, 32'h0000_0010);
    rec(2'd3, 20, 32, 16'h0000);
    reg_wr(cre_pkg::REG_SNAP, 32'h0000_0030);
    reg_wr(cre_pkg::REG_CTRL, 32'h0000_0F03);
    rec(2'd0, 12, 32, 16'h0000);
    `CHK(host_u.mem.exists(base + 32'd28), 1)
    `CHK(host_u.mem[base + 32'd28], 32'h0000_0000)
    reg_wr(cre_pkg::REG_CTRL, 32'h0000_0F00);
    rec(2'd1, 8, 64, 16'h0000);
    `CHK(host_u.mem.exists(base + 32'd60), 1)
    `CHK(host_u.mem[base + 32'd60], 32'h0000_0000)
    reg_wr(cre_pkg::REG_CTRL, 32'h0000_0701);
    send_pkt(2'd3, 8);
    reg_rd(cre_pkg::REG_WR_PTR);
    `CHK(rd, wp)
    reg_wr(cre_pkg::REG_CTRL, 32'h0000_0F01);
  endtask
  task automatic t_full;
    int flips;
    logic led;
    flips = 0;
    // read pointer just ahead of the write pointer leaves too little room
    reg_wr(cre_pkg::REG_RD_PTR, wp + 32'd32);
    send_pkt(2'd0, 8);
    reg_rd(cre_pkg::REG_WR_PTR);
    `CHK(rd, wp)
    reg_rd(cre_pkg::REG_LOSS);
    `CHK(rd, 32'h0000_0001)
    led = o_capture_led;
    repeat (40) begin
      @(posedge i_clk);
      flips += (o_capture_led !== led);
      led = o_capture_led;
    end
    `CHK(flips > 2, 1'b1)
    reg_wr(cre_pkg::REG_RD_PTR, wp);
    rec(2'd0, 8, 24, 16'h0001);
  endtask
  task automatic t_rxtx;
    reg_wr(cre_pkg::REG_CTRL, 32'h0000_0F05);
    reg_rd(cre_pkg::REG_MEM);
    `CHK(rd, 32'h0010_0010)
    `CHK(o_tx_ready, 1'b1)
    line_q.delete();
    fork
      host_u.send_rec(6, 8'h5A);
      rec(2'd1, 8, 24, 16'h0000);
    join
    repeat (4) @(posedge i_clk);
    `CHK(line_q.size(), 2)
    `CHK(line_q[0], 32'hBEEF_0004)
    `CHK(line_q[1], 32'hBEEF_0005)
    // too large a transmit share is refused, a legal one is taken
    reg_wr(cre_pkg::REG_MEM, 32'h0000_0020);
    reg_rd(cre_pkg::REG_MEM);
    `CHK(rd, 32'h0010_0010)
    reg_wr(cre_pkg::REG_MEM, 32'h0000_0008);
    reg_rd(cre_pkg::REG_MEM);
    `CHK(rd, 32'h0018_0008)
    reg_rd(cre_pkg::REG_STATUS);
    `CHK(rd, 32'h0000_0000)
    reg_rd(cre_pkg::REG_CTRL);
    `CHK(rd, 32'h0000_0F01)
  endtask
  task automatic final_report;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    t_defaults;
    t_lengths;
    t_full;
    t_rxtx;
    final_report;
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      final_report;
    end
  end
endmodule
`default_nettype wire
